// ===== hw/ref_switch_pkg.sv
// Behaviour
// - word 0 bit 30 picks automatic or manual reference selection
// - manual mode: select pin 1 picks primary, 0 picks secondary
// - automatic mode prefers primary, uses secondary only while primary fails
// - reference changeover never produces a runt or truncated pulse
// - lock rises after the configured count of consecutive good cycles
// - out-of-lock on an edge outside the window or a frequency offset
// - window size and cycle count come from word 3 bits 2 to 5
// - window centred on reference edge, half width either side
// - digital lock drops on the first bad cycle
// - analog lock charges per good cycle, discharges after lock loss
// - digital or analog indication selectable, both show lock high
// - five pairs, differential or single-ended, each single-ended output own enable/invert
// - after reset all five pairs are differential
// - every output may be put in a high-impedance disabled state
// - divider defaults to /16; word 1 bits 30/31 give shifted /4 or /8
// - shifted mode removes /16, switches pairs, shifted signal lags
// - single-ended disabled-driven-low and inversion; with shift gives 270
// - shifted outputs align to reference when divider drives feedback
// - every word is writable through the 3-wire serial port; serial bits 1:0 pick the word, so its bits 1:0 hold the address
// - reference below minimum rate forces reference status low
// - feedback below minimum rate forces oscillator status and lock low
// - word 3 bits 4 and 5 set the lock count, not the unlock decision
`default_nettype none
package ref_switch_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] ADDR_WORD0 = 5'h00;
  localparam logic [4:0] ADDR_WORD3 = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // field positions
  localparam int AUTO_BIT = 30;
  localparam int MUX_LSB = 0;
  localparam int EN_LSB = 0;
  localparam int INV_LSB = 10;
  localparam int SE_LSB = 20;
  localparam int ANALOG_BIT = 29;
  localparam int DIV4_BIT = 30;
  localparam int DIV8_BIT = 31;
  localparam int LOWDRV_LSB = 0;
  localparam int WIN_LSB = 2;
  localparam int CNT_LSB = 4;
  localparam int SLIP_BIT = 6;
  // ==========================================================
  // reset values
  localparam logic [31:0] WORD0_RST = 32'h0000_0000;
  localparam logic [31:0] WORD1_RST = 32'h0000_03ff;
  localparam logic [31:0] WORD2_RST = 32'h0000_0002;
  localparam logic [31:0] WORD3_RST = 32'h0000_0003;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int MIN_FREQ_HZ = 2_000_000;
  localparam logic [7:0] ACT_TIMEOUT = 8'(CLK_HZ / MIN_FREQ_HZ);
  localparam int WIN0_PS = 3500;
  localparam int WIN1_PS = 8500;
  localparam int WIN2_PS = 18500;
  localparam int H0 = WIN0_PS / 2 / CLK_PS;
  localparam int H1 = WIN1_PS / 2 / CLK_PS;
  localparam int H2 = WIN2_PS / 2 / CLK_PS;
  localparam logic [7:0] HALF0 = 8'((H0 < 1) ? 1 : H0);
  localparam logic [7:0] HALF1 = 8'((H1 < 1) ? 1 : H1);
  localparam logic [7:0] HALF2 = 8'((H2 < 1) ? 1 : H2);
  localparam logic [8:0] LOCK_CNT0 = 9'h002;
  localparam logic [8:0] LOCK_CNT1 = 9'h010;
  localparam logic [8:0] LOCK_CNT2 = 9'h040;
  localparam logic [8:0] LOCK_CNT3 = 9'h100;
  localparam logic [7:0] ANA_STEP = 8'h08;
  localparam logic [7:0] ANA_THR = 8'hc0;
endpackage
`default_nettype wire

// ===== hw/ref_switch_lock_detect_outsel.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module ref_switch_lock_detect_outsel #(
  parameter int PAIRS = 5
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial configuration port
  input wire logic ctrl_clk,
  input wire logic ctrl_data,
  input wire logic ctrl_le,
  // reference and feedback clocks
  input wire logic primary_ref_clock,
  input wire logic secondary_ref_clock,
  input wire logic ref_select_pin,
  input wire logic feedback_osc_input,
  // status
  output logic selected_ref,
  output logic pll_lock,
  output logic ref_status,
  output logic active_ref_indicator,
  output logic osc_valid_status,
  // clock outputs
  output logic [PAIRS-1:0] y_a,
  output logic [PAIRS-1:0] y_b,
  output logic [PAIRS-1:0] y_a_oe,
  output logic [PAIRS-1:0] y_b_oe
);
  // ==========================================================
  // configuration words
  logic [31:0] word [4];
  logic [31:0] shift_sr;
  logic ctrl_clk_d, ctrl_le_d;
  logic aw_full, w_full, do_write, addr_ok;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] status;

  // serial port edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_clk_d <= 1'b0;
      ctrl_le_d <= 1'b0;
      shift_sr <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_clk_d <= ctrl_clk;
      ctrl_le_d <= ctrl_le;
      if (ctrl_clk && !ctrl_clk_d) begin
        shift_sr <= {shift_sr[30:0], ctrl_data};
      end
    end
  end

  assign addr_ok = (aw_addr <= ref_switch_pkg::ADDR_WORD3);
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  // word store: serial latch wins over a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word[0] <= ref_switch_pkg::WORD0_RST;
      word[1] <= ref_switch_pkg::WORD1_RST;
      word[2] <= ref_switch_pkg::WORD2_RST;
      word[3] <= ref_switch_pkg::WORD3_RST;
    end else if (ce) begin
      if (ctrl_le && !ctrl_le_d) begin
        word[shift_sr[1:0]] <= shift_sr;
      end else if (do_write && addr_ok) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            word[aw_addr[3:2]][8*b +: 8] <= w_data[8*b +: 8];
          end
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ref_switch_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok ? ref_switch_pkg::RESP_OKAY
                               : ref_switch_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ref_switch_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ref_switch_pkg::RESP_OKAY;
        if (s_axi_araddr <= ref_switch_pkg::ADDR_WORD3) begin
          s_axi_rdata <= word[s_axi_araddr[3:2]];
        end else if (s_axi_araddr == ref_switch_pkg::ADDR_STATUS) begin
          s_axi_rdata <= status;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ref_switch_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // input sampling and activity monitors
  logic [2:0] src_in, src_q, src_d, src_rise, act_ok;
  logic [7:0] act_cnt [3];
  assign src_in = {feedback_osc_input, secondary_ref_clock,
                   primary_ref_clock};
  assign src_rise = src_q & ~src_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 3'h0;
      src_d <= 3'h0;
    end else if (ce) begin
      src_q <= src_in;
      src_d <= src_q;
    end
  end

  // a source is alive while its rising edges come faster than the floor
  for (genvar g = 0; g < 3; g++) begin : g_act
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        act_cnt[g] <= ref_switch_pkg::ACT_TIMEOUT;
      end else if (ce) begin
        if (src_rise[g]) begin
          act_cnt[g] <= 8'h00;
        end else if (act_cnt[g] < ref_switch_pkg::ACT_TIMEOUT) begin
          act_cnt[g] <= act_cnt[g] + 8'h01;
        end
      end
    end
    assign act_ok[g] = act_cnt[g] < ref_switch_pkg::ACT_TIMEOUT;
  end

  // ==========================================================
  // reference selection
  logic want_pri, cur_pri, cur_lvl, new_lvl, cur_ok, sel_d, ref_rise;
  assign want_pri = word[0][ref_switch_pkg::AUTO_BIT]
                  ? act_ok[0]
                  : ref_select_pin;
  assign cur_lvl = cur_pri ? src_q[0] : src_q[1];
  assign new_lvl = cur_pri ? src_q[1] : src_q[0];
  assign cur_ok = cur_pri ? act_ok[0] : act_ok[1];

  // change over only while the incoming clock is low and the outgoing
  // one is low or dead, so the merged clock never shows a runt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_pri <= 1'b1;
      selected_ref <= 1'b0;
      sel_d <= 1'b0;
    end else if (ce) begin
      if (want_pri != cur_pri && !new_lvl && (!cur_lvl || !cur_ok)) begin
        cur_pri <= want_pri;
        selected_ref <= 1'b0;
      end else begin
        selected_ref <= cur_lvl;
      end
      sel_d <= selected_ref;
    end
  end
  assign ref_rise = selected_ref && !sel_d;

  // reference status follows the monitor of the reference in use, oscillator status the feedback monitor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_status <= 1'b0;
      active_ref_indicator <= 1'b1;
      osc_valid_status <= 1'b0;
    end else if (ce) begin
      ref_status <= cur_pri ? act_ok[0] : act_ok[1];
      active_ref_indicator <= cur_pri;
      osc_valid_status <= act_ok[2];
    end
  end

  // ==========================================================
  // lock detection at the phase_freq_detector
  logic fb_rise, hit, phase_ok, offset, cycle_ok, dig_lock, ana_lock;
  logic [7:0] since_ref, since_fb, half;
  logic [1:0] fb_n, win_sel, cnt_sel;
  logic [8:0] good_cnt, need;
  logic [7:0] charge;
  logic discharging;
  assign fb_rise = src_rise[2];
  assign win_sel = word[3][ref_switch_pkg::WIN_LSB +: 2];
  assign cnt_sel = word[3][ref_switch_pkg::CNT_LSB +: 2];

  always_comb begin
    unique case (win_sel)
      2'b00: half = ref_switch_pkg::HALF0;
      2'b01: half = ref_switch_pkg::HALF1;
      2'b10: half = ref_switch_pkg::HALF2;
      2'b11: half = 8'hff;
    endcase
    unique case (cnt_sel)
      2'b00: need = ref_switch_pkg::LOCK_CNT0;
      2'b01: need = ref_switch_pkg::LOCK_CNT1;
      2'b10: need = ref_switch_pkg::LOCK_CNT2;
      2'b11: need = ref_switch_pkg::LOCK_CNT3;
    endcase
  end

  // a cycle passes if a feedback edge lies within half a window of the
  // reference edge, early or late, and, with word 3 bit 6 set, exactly one arrived per cycle
  assign phase_ok = hit || fb_rise || (since_fb <= half);
  assign offset = word[3][ref_switch_pkg::SLIP_BIT] && (fb_n != 2'd1);
  assign cycle_ok = phase_ok && !offset;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_ref <= 8'hff;
      since_fb <= 8'hff;
      hit <= 1'b0;
      fb_n <= 2'd0;
    end else if (ce) begin
      if (ref_rise) begin
        since_ref <= 8'h00;
        hit <= fb_rise;
        fb_n <= fb_rise ? 2'd1 : 2'd0;
      end else begin
        if (since_ref != 8'hff) begin
          since_ref <= since_ref + 8'h01;
        end
        if (fb_rise) begin
          hit <= hit || (since_ref < half);
          fb_n <= (fb_n == 2'd3) ? 2'd3 : fb_n + 2'd1;
        end
      end
      if (fb_rise) begin
        since_fb <= 8'h00;
      end else if (since_fb != 8'hff) begin
        since_fb <= since_fb + 8'h01;
      end
    end
  end

  // digital lock: consecutive good cycles set it, one bad cycle clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_cnt <= 9'h000;
      dig_lock <= 1'b0;
    end else if (ce) begin
      if (!act_ok[2]) begin
        good_cnt <= 9'h000;
        dig_lock <= 1'b0;
      end else if (ref_rise) begin
        if (!cycle_ok) begin
          good_cnt <= 9'h000;
          dig_lock <= 1'b0;
        end else if (good_cnt + 9'h001 >= need) begin
          dig_lock <= 1'b1;
        end else begin
          good_cnt <= good_cnt + 9'h001;
        end
      end
    end
  end

  // analog lock: charge pot filled per good cycle, bled after a bad one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge <= 8'h00;
      discharging <= 1'b0;
    end else if (ce) begin
      if (!act_ok[2]) begin
        charge <= 8'h00;
        discharging <= 1'b1;
      end else if (ref_rise && cycle_ok) begin
        discharging <= 1'b0;
        charge <= (charge > 8'hff - ref_switch_pkg::ANA_STEP) ? 8'hff
                : charge + ref_switch_pkg::ANA_STEP;
      end else if (ref_rise) begin
        discharging <= 1'b1;
      end else if (discharging && charge != 8'h00) begin
        charge <= charge - 8'h01;
      end
    end
  end
  assign ana_lock = charge >= ref_switch_pkg::ANA_THR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_lock <= 1'b0;
    end else if (ce) begin
      pll_lock <= act_ok[2] && (word[1][ref_switch_pkg::ANALOG_BIT]
                 ? ana_lock : dig_lock);
    end
  end

  assign status = {16'h0000, charge, 1'b0, dig_lock, ana_lock, pll_lock,
                   act_ok[2], act_ok[1], act_ok[0], cur_pri};

  // ==========================================================
  // sixteen_stage_divider and output stage
  logic [3:0] p16_cnt;
  logic p16_out, div4_on, div8_on;
  assign div4_on = word[1][ref_switch_pkg::DIV4_BIT];
  assign div8_on = word[1][ref_switch_pkg::DIV8_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p16_cnt <= 4'h0;
    end else if (ce && fb_rise) begin
      p16_cnt <= p16_cnt + 4'h1;
    end
  end

  // quarter-period lagging taps replace the /16 tap in shifted mode
  always_comb begin
    if (div8_on) begin
      p16_out = ~(p16_cnt[2] ^ p16_cnt[1]);
    end else if (div4_on) begin
      p16_out = ~(p16_cnt[1] ^ p16_cnt[0]);
    end else begin
      p16_out = p16_cnt[3];
    end
  end

  // per pair output_source_mux, enable, inversion and pairing
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    logic src, se, en_a, en_b, inv_a, inv_b, ld_a, ld_b;
    assign src = word[0][ref_switch_pkg::MUX_LSB + p]
               ? p16_out : src_q[2];
    assign se = word[1][ref_switch_pkg::SE_LSB + p];
    assign en_a = word[1][ref_switch_pkg::EN_LSB + 2*p];
    assign en_b = word[1][ref_switch_pkg::EN_LSB + 2*p + 1];
    assign inv_a = word[1][ref_switch_pkg::INV_LSB + 2*p];
    assign inv_b = word[1][ref_switch_pkg::INV_LSB + 2*p + 1];
    assign ld_a = word[2][ref_switch_pkg::LOWDRV_LSB + 2*p];
    assign ld_b = word[2][ref_switch_pkg::LOWDRV_LSB + 2*p + 1];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        y_a[p] <= 1'b0;
        y_b[p] <= 1'b0;
        y_a_oe[p] <= 1'b0;
        y_b_oe[p] <= 1'b0;
      end else if (ce) begin
        if (se) begin
          y_a[p] <= en_a && (src ^ inv_a);
          y_b[p] <= en_b && (src ^ inv_b);
          y_a_oe[p] <= en_a || ld_a;
          y_b_oe[p] <= en_b || ld_b;
        end else begin
          y_a[p] <= en_a && src;
          y_b[p] <= en_a && !src;
          y_a_oe[p] <= en_a;
          y_b_oe[p] <= en_a;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/ref_switch_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bus handshake and output checks at the top ports
module ref_switch_monitor #(
  parameter int PAIRS = 5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ctrl_le,
  // status and outputs
  input wire logic selected_ref,
  input wire logic pll_lock,
  input wire logic osc_valid_status,
  input wire logic [PAIRS-1:0] y_a_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [2:0] since_cfg;
  // cycles since the last reset, bus write or serial latch
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid || ctrl_le) begin
      since_cfg <= 3'h0;
    end else if (since_cfg != 3'h7) begin
      since_cfg <= since_cfg + 3'h1;
    end
  end
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no bvalid");
  a_no_runt: assert property ($rose(selected_ref) |->
    selected_ref [*4]) else $error("runt reference pulse");
  a_reset_enables: assert property ($rose(aresetn) |-> ##2
    y_a_oe == {PAIRS{1'b1}}) else $error("outputs not enabled");
  a_lock_needs_fb: assert property (!osc_valid_status [*3] |->
    !pll_lock) else $error("lock without feedback");
  a_cfg_atomic: assert property ($changed(y_a_oe) |->
    since_cfg < 3'h5) else $error("output enable moved alone");
endmodule
bind ref_switch_lock_detect_outsel ref_switch_monitor #(.PAIRS(PAIRS)) mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .ctrl_le, .selected_ref, .pll_lock, .osc_valid_status,
  .y_a_oe
);
`default_nettype wire

// ===== sim/ref_source_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// reference sources and oscillator feedback
module ref_source_model (
  // run controls
  input wire logic run_pri,
  input wire logic run_sec,
  input wire logic run_fb,
  input wire logic fast_fb,
  // clocks
  output logic primary_ref_clock,
  output logic secondary_ref_clock,
  output logic feedback_osc_input
);
  // primary and feedback share one 60 ns tick, so restarts stay in phase
  logic [1:0] k = 2'h0;
  initial begin
    primary_ref_clock = 1'b0;
    feedback_osc_input = 1'b0;
    forever begin
      #60;
      k = k + 2'h1;
      if (!k[0]) primary_ref_clock = run_pri & k[1];
      feedback_osc_input = run_fb & (fast_fb ? k[0] : k[1]);
    end
  end
  // secondary: 280 ns period, parks low when it fails
  initial begin
    secondary_ref_clock = 1'b0;
    forever begin
      #140;
      secondary_ref_clock = run_sec ? ~secondary_ref_clock : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench
module tb;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [4:0] s_axi_awaddr, s_axi_araddr, y_a, y_b, y_a_oe, y_b_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, exp2, rnd;
  logic [3:0] s_axi_wstrb, strb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ctrl_clk, ctrl_data;
  logic ctrl_le, primary_ref_clock, secondary_ref_clock, ref_select_pin;
  logic feedback_osc_input, selected_ref, pll_lock, ref_status;
  logic active_ref_indicator, osc_valid_status;
  logic run_pri, run_sec, run_fb, fast_fb;
  int errors, tests_run, n;
  ref_switch_lock_detect_outsel #(.PAIRS(5)) DUT (.aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_clk,
    .ctrl_data, .ctrl_le, .primary_ref_clock, .secondary_ref_clock,
    .ref_select_pin, .feedback_osc_input, .selected_ref, .pll_lock,
    .ref_status, .active_ref_indicator, .osc_valid_status, .y_a, .y_b,
    .y_a_oe, .y_b_oe);
  ref_source_model src (.run_pri, .run_sec, .run_fb, .fast_fb,
    .primary_ref_clock, .secondary_ref_clock, .feedback_osc_input);
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ==========================================================
  // expectations and checks
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = d[8*b +: 8];
    return o;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want,
      input string what);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    errors++;
    $display("wrong value at %0t: %s timed out", $time, what);
    final_report();
  endtask
  // wait for a status output to reach a level, cycles waited in n
  task automatic wait_for(input int sel, input logic v, input int lim,
      input string what);
    logic s;
    for (n = 0; n < lim; n++) begin
      @(posedge aclk);
      s = sel == 0 ? pll_lock : sel == 1 ? active_ref_indicator :
          sel == 2 ? ref_status : osc_valid_status;
      if (s === v) break;
    end
    tests_run++;
    if (n == lim) give_up(what);
  endtask
  // ==========================================================
  // bus and serial masters
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 100) give_up("write");
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [4:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 100) give_up("read");
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ser_write(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ctrl_data <= w[i];
      repeat (2) @(posedge aclk);
      ctrl_clk <= 1'b1;
      repeat (2) @(posedge aclk);
      ctrl_clk <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    ctrl_le <= 1'b1;
    repeat (2) @(posedge aclk);
    ctrl_le <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {errors, tests_run, n} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ctrl_clk, ctrl_data, ctrl_le} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {ce, ref_select_pin, run_pri, run_sec, run_fb, fast_fb} = 6'h3e;
    rnd = $urandom(87746);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of the four words
    for (int i = 0; i < 4; i++) begin
      axi_read(5'(i * 4));
      check(rd, i == 0 ? ref_switch_pkg::WORD0_RST : i == 1 ?
        ref_switch_pkg::WORD1_RST : i == 2 ? ref_switch_pkg::WORD2_RST :
        ref_switch_pkg::WORD3_RST, "reset word");
    end
    axi_read(5'h14);
    check(rd, 32'h0, "hole data");
    check(32'(resp), 32'(ref_switch_pkg::RESP_SLVERR), "hole");
    axi_write(ref_switch_pkg::ADDR_STATUS, 32'hffff_ffff, 4'hf);
    check(32'(resp), 32'(ref_switch_pkg::RESP_SLVERR), "status write");
    // random strobed writes merge into word 2
    exp2 = ref_switch_pkg::WORD2_RST;
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom;
      strb = 4'($urandom_range(15, 1));
      axi_write(5'h08, rnd, strb);
      exp2 = merge(exp2, rnd, strb);
      axi_read(5'h08);
      check(rd, exp2, "strobe merge");
    end
    // manual selection and digital lock
    wait_for(0, 1'b1, 400, "lock");
    check(32'({active_ref_indicator, ref_status}), 32'h3, "primary");
    ref_select_pin <= 1'b0;
    wait_for(1, 1'b0, 200, "manual secondary");
    // automatic selection set over the serial port
    ser_write(32'h1 << ref_switch_pkg::AUTO_BIT);
    wait_for(1, 1'b1, 200, "auto primary");
    axi_read(ref_switch_pkg::ADDR_WORD0);
    check(rd, 32'h1 << ref_switch_pkg::AUTO_BIT, "serial word");
    run_pri <= 1'b0;
    wait_for(1, 1'b0, 300, "fail over");
    wait_for(2, 1'b1, 100, "secondary alive");
    run_pri <= 1'b1;
    wait_for(1, 1'b1, 300, "return");
    {run_pri, run_sec} <= 2'h0;
    wait_for(2, 1'b0, 300, "ref dead");
    {run_pri, run_sec} <= 2'h3;
    wait_for(0, 1'b1, 500, "relock");
    // frequency offset breaks a digital lock at once
    axi_write(ref_switch_pkg::ADDR_WORD3, 32'h43, 4'hf);
    fast_fb <= 1'b1;
    wait_for(0, 1'b0, 60, "offset unlock");
    fast_fb <= 1'b0;
    wait_for(0, 1'b1, 400, "offset relock");
    // longer lock count, and feedback loss
    axi_write(ref_switch_pkg::ADDR_WORD3, 32'h13, 4'hf);
    run_fb <= 1'b0;
    wait_for(3, 1'b0, 100, "fb dead");
    wait_for(0, 1'b0, 5, "lock without fb");
    run_fb <= 1'b1;
    wait_for(0, 1'b1, 1000, "count lock");
    check(32'(n > 150), 32'h1, "lock count too short");
    // analog indication charges over many good cycles
    axi_write(ref_switch_pkg::ADDR_WORD3, ref_switch_pkg::WORD3_RST, 4'hf);
    axi_write(5'h04, 32'h2000_03ff, 4'hf);
    run_fb <= 1'b0;
    wait_for(0, 1'b0, 100, "analog drop");
    repeat (300) @(posedge aclk);
    run_fb <= 1'b1;
    wait_for(0, 1'b1, 1000, "analog lock");
    check(32'(n > 200), 32'h1, "analog too fast");
    // pair 0 single ended, A disabled low, others off
    axi_write(5'h04, 32'h0010_0002, 4'hf);
    axi_write(5'h08, 32'h1, 4'hf);
    repeat (4) @(posedge aclk);
    check(32'({y_a_oe, y_a[0]}), 32'h02, "drive low");
    check(32'(y_b_oe), 32'h01, "pair enables");
    // second reset restores defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(5'h04);
    check(rd, ref_switch_pkg::WORD1_RST, "reset again");
    final_report();
  end
endmodule
`default_nettype wire
